/* prw_pkg.sv */
// Shared constants and types for the paged ROM window decoder.
// Assumes a 22-bit byte address bus and 16-bit words.
package prw_pkg;

  // ---------------------------------------------------------------
  // Bus geometry
  // ---------------------------------------------------------------
  localparam int BUS_AW = 22;
  localparam int SEG_W = 10;
  localparam int ARR_AW = 18;
  localparam int PAGE_W = 7;
  localparam int OFF_W = 11;
  localparam int LOW_W = 12;
  localparam int SEG_LSB = 12;
  localparam int IO_LSB = 13;
  localparam int WIN_BIT = 11;

  // ---------------------------------------------------------------
  // Address-width modes and I/O page detection
  // ---------------------------------------------------------------
  localparam logic [1:0] AMODE_22 = 2'h0;
  localparam logic [1:0] AMODE_18 = 2'h1;
  localparam logic [1:0] AMODE_16 = 2'h2;
  localparam logic [21:0] KEEP_22 = 22'h3fffff;
  localparam logic [21:0] KEEP_18 = 22'h03ffff;
  localparam logic [21:0] KEEP_16 = 22'h00ffff;
  localparam logic [8:0] IOMASK_22 = 9'h1ff;
  localparam logic [8:0] IOMASK_18 = 9'h01f;
  localparam logic [8:0] IOMASK_16 = 9'h007;
  localparam logic [11:0] CTL_WORD_BASE = 12'hf00;

  // ---------------------------------------------------------------
  // Control register layout
  // ---------------------------------------------------------------
  localparam int CTL_W = 16;
  localparam logic [15:0] CTL_RESET = 16'h0000;
  localparam int CTL_PAGE0_LSB = 0;
  localparam int CTL_PAGE1_LSB = 8;
  localparam int CTL_OPEN_BIT = 15;

  // ---------------------------------------------------------------
  // Array decoder patterns
  // ---------------------------------------------------------------
  localparam logic [1:0] PAT_2K_HALF = 2'h0;
  localparam logic [1:0] PAT_2K_FULL = 2'h1;
  localparam logic [1:0] PAT_4K_FULL = 2'h2;
  localparam logic [1:0] PAT_8K_FULL = 2'h3;
  localparam logic [17:0] CAP_2K_HALF = 18'h04000;
  localparam logic [17:0] CAP_2K_FULL = 18'h08000;
  localparam logic [17:0] CAP_4K_FULL = 18'h10000;
  localparam logic [17:0] CAP_8K_FULL = 18'h20000;
  localparam int SET_SH_2K = 12;
  localparam int SET_SH_4K = 13;
  localparam int SET_SH_8K = 14;
  localparam int NUM_SETS = 8;

  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_LOOK = 2'h1,
    ST_ANSWER = 2'h3
  } prw_state_type;

  typedef struct packed {
    prw_state_type state;
    logic [17:0] mem_addr;
    logic [7:0] set;
    logic write;
    logic [1:0] lanes;
    logic [15:0] wdata;
    logic [15:0] rdata;
    logic ctl_hit;
  } prw_main_state_type;

  typedef struct packed {
    logic [15:0] value;
  } prw_ctl_state_type;

endpackage : prw_pkg

/* prw_page_reg.sv */
// Page window control register with word and byte writes.
// Assumes the caller qualifies the write strobe with the bus decode.
`timescale 1ns/1ps
module prw_page_reg
  import prw_pkg::*;
(
  input wire logic ref_clk_in,
  input wire logic reset_in,
  input wire logic ce_in,
  input wire logic bus_init_in,
  input wire logic wr_in,
  input wire logic [1:0] lanes_in,
  input wire logic [prw_pkg::CTL_W-1:0] wdata_in,
  output logic [prw_pkg::CTL_W-1:0] value_out
);
  import prw_pkg::*;

  prw_ctl_state_type r;
  prw_ctl_state_type r_nxt;

  always_comb begin
    r_nxt = r;
    if (bus_init_in) begin
      r_nxt.value = CTL_RESET; // R14
    end else if (wr_in) begin
      if (lanes_in[0]) begin
        r_nxt.value[7:0] = wdata_in[7:0]; // R10 R23
      end
      if (lanes_in[1]) begin
        r_nxt.value[15:8] = wdata_in[15:8]; // R10 R23
      end
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      r.value <= CTL_RESET; // R14
    end else if (ce_in) begin
      r <= r_nxt;
    end
  end

  assign value_out = r.value;

  chk_ctl_init_clear: assert property ( // R14
    @(posedge ref_clk_in) disable iff (reset_in)
    (ce_in && bus_init_in) |=> (value_out == CTL_RESET))
    else $error("control register not cleared by restart");

endmodule : prw_page_reg

/* prw_array_decoder.sv */
// Array decoder: range check and chip-set select per pattern.
// Assumes all devices share one size, as the standard decoder needs.
`timescale 1ns/1ps
module prw_array_decoder
  import prw_pkg::*;
(
  input wire logic [1:0] pattern_in,
  input wire logic [prw_pkg::ARR_AW-1:0] addr_in,
  output logic in_range_out,
  output logic [prw_pkg::NUM_SETS-1:0] set_out
);
  import prw_pkg::*;

  logic [ARR_AW-1:0] cap;
  logic [ARR_AW-1:0] set_idx;

  always_comb begin
    case (pattern_in) // R17
      PAT_2K_HALF: begin
        cap = CAP_2K_HALF;
        set_idx = addr_in >> SET_SH_2K;
      end
      PAT_2K_FULL: begin
        cap = CAP_2K_FULL;
        set_idx = addr_in >> SET_SH_2K;
      end
      PAT_4K_FULL: begin
        cap = CAP_4K_FULL;
        set_idx = addr_in >> SET_SH_4K;
      end
      default: begin
        cap = CAP_8K_FULL;
        set_idx = addr_in >> SET_SH_8K;
      end
    endcase
  end

  assign in_range_out = addr_in < cap; // R3

  // One low/high byte device pair per set
  for (genvar g = 0; g < NUM_SETS; g++) begin : g_set // R16
    assign set_out[g] = in_range_out && (set_idx == ARR_AW'(g));
  end

endmodule : prw_array_decoder

/* prw_window_decoder.sv */
// Contract
// (R1) Addressing mode comes only from a static configuration input.
// (R2) Direct mode maps array one-to-one onto a range of its capacity.
// (R3) Direct range limits come from start address and decoder pattern.
// (R4) Start address lies on 4 KB boundaries, zero to octal 17770000.
// (R5) Main array never answers inside the I/O page.
// (R6) In direct mode only bootstrap areas may answer in the I/O page.
// (R7) Paged mode claims a 4 KB segment plus one control register.
// (R8) Control register sits at one of sixteen I/O page locations.
// (R9) Segment splits into two 2 KB windows, each showing a chosen page.
// (R10) Low byte pages window 0, high byte window 1; rewrite remaps.
// (R11) Bits 7 and 15 are not page bits; bit 15 is the enable.
// (R12) Bit 15 set opens both windows onto their selected pages.
// (R13) Bit 15 clear closes windows; no reply, master times out.
// (R14) Power-up and bus restart clear the whole control register.
// (R15) Master loads page and enable before using a window.
// (R16) Array is eight chip sets, each a low and a high byte device.
// (R17) Standard patterns: 2K half, 2K, 4K or 8K fully populated.
// (R18) An option allows or inhibits reply to write cycles.
// (R19) Decoder works for 22-bit, 18-bit and 16-bit buses.
// (R20) Bus address bits 0 to 11 pass straight to array bits 0 to 11; paged mode passes only bits 0 to 10.
// (R21) Out-of-range high address bits withhold the reply.
// (R22) Offset bit 11 picks window; array address is page times 2048 plus offset.
// (R23) Control register takes word and byte writes and reads back.
//
// Top: decodes a bus request, drives the array, answers with reply.
// Assumes request inputs hold steady from req_in until reply_out.
`timescale 1ns/1ps
module prw_window_decoder
  import prw_pkg::*;
#(
  parameter int BUS_AW_P = 22
) (
  input wire logic ref_clk_in,
  input wire logic reset_in,
  input wire logic ce_in,
  input wire logic bus_init_in,
  input wire logic cfg_paged_in,
  input wire logic [prw_pkg::SEG_W-1:0] cfg_start_in,
  input wire logic [1:0] cfg_pattern_in,
  input wire logic [3:0] cfg_ctl_sel_in,
  input wire logic cfg_write_ok_in,
  input wire logic [1:0] cfg_addr_mode_in,
  input wire logic req_in,
  input wire logic [prw_pkg::BUS_AW-1:0] req_addr_in,
  input wire logic req_write_in,
  input wire logic req_byte_in,
  input wire logic [15:0] req_wdata_in,
  output logic reply_out,
  output logic [15:0] rdata_out,
  output logic [prw_pkg::ARR_AW-1:0] mem_addr_out,
  output logic [prw_pkg::NUM_SETS-1:0] mem_set_out,
  output logic mem_strobe_out,
  output logic mem_write_out,
  output logic [1:0] mem_lanes_out,
  output logic [15:0] mem_wdata_out,
  input wire logic [15:0] mem_rdata_in
);
  import prw_pkg::*;

  // ---------------------------------------------------------------
  // Elaboration check
  // ---------------------------------------------------------------
  if (BUS_AW_P != BUS_AW) begin : g_bad_width
    $error("prw_window_decoder serves a 22-bit bus only");
  end

  prw_main_state_type r;
  prw_main_state_type r_nxt;

  logic [CTL_W-1:0] ctl_value;
  logic [BUS_AW-1:0] keep;
  logic [8:0] io_mask;
  logic [BUS_AW-1:0] eff;
  logic io_page;
  logic [SEG_W-1:0] norm;
  logic below;
  logic seg_hit;
  logic [PAGE_W-1:0] page;
  logic [ARR_AW-1:0] direct_addr;
  logic [ARR_AW-1:0] paged_addr;
  logic [ARR_AW-1:0] arr_addr;
  logic in_range;
  logic [NUM_SETS-1:0] set_sel;
  logic array_hit;
  logic ctl_hit;
  logic write_ok;
  logic take;
  logic ctl_wr;
  logic [1:0] lanes;

  // ---------------------------------------------------------------
  // Address qualification
  // ---------------------------------------------------------------
  always_comb begin
    case (cfg_addr_mode_in) // R19
      AMODE_18: begin
        keep = KEEP_18;
        io_mask = IOMASK_18;
      end
      AMODE_16: begin
        keep = KEEP_16;
        io_mask = IOMASK_16;
      end
      default: begin
        keep = KEEP_22;
        io_mask = IOMASK_22;
      end
    endcase
  end

  // Short buses may leave high lines set, so mask them off
  assign eff = req_addr_in & keep; // R19
  assign io_page = &(eff[BUS_AW-1:IO_LSB] | ~io_mask);

  // Start address only as 4 KB units, so alignment is built in
  assign norm = eff[BUS_AW-1:SEG_LSB] - cfg_start_in; // R4 R3
  assign below = eff[BUS_AW-1:SEG_LSB] < cfg_start_in; // R3
  assign direct_addr = {norm[ARR_AW-SEG_LSB-1:0], eff[LOW_W-1:0]}; // R2 R20

  assign seg_hit = eff[BUS_AW-1:SEG_LSB] == cfg_start_in; // R7
  assign page = eff[WIN_BIT] ? ctl_value[CTL_PAGE1_LSB +: PAGE_W]
                             : ctl_value[CTL_PAGE0_LSB +: PAGE_W]; // R9 R11 R22
  assign paged_addr = {page, eff[OFF_W-1:0]}; // R22 R20

  // Mode is a strap only; no register bit reaches this select
  assign arr_addr = cfg_paged_in ? paged_addr : direct_addr; // R1

  prw_array_decoder u_decoder (
    .pattern_in(cfg_pattern_in),
    .addr_in(arr_addr),
    .in_range_out(in_range),
    .set_out(set_sel)
  );

  // High normalised bits set means beyond any array, 18..21 included
  always_comb begin
    if (io_page) begin
      array_hit = 1'b0; // R5 R6
    end else if (cfg_paged_in) begin
      array_hit = seg_hit && ctl_value[CTL_OPEN_BIT] && in_range; // R12 R13
    end else begin
      array_hit = !below && (norm[SEG_W-1:ARR_AW-SEG_LSB] == '0) && in_range; // R2 R21
    end
  end

  assign ctl_hit = cfg_paged_in && io_page &&
                   (eff[IO_LSB-1:1] == (CTL_WORD_BASE + {8'h00, cfg_ctl_sel_in})); // R8
  assign write_ok = !req_write_in || cfg_write_ok_in; // R18
  assign take = ce_in && req_in && (r.state == ST_IDLE) &&
                (ctl_hit || (array_hit && write_ok));
  assign lanes = !req_byte_in ? 2'h3 : (eff[0] ? 2'h2 : 2'h1);
  assign ctl_wr = take && ctl_hit && req_write_in; // R23

  // ---------------------------------------------------------------
  // Control register
  // ---------------------------------------------------------------
  prw_page_reg u_ctl (
    .ref_clk_in(ref_clk_in),
    .reset_in(reset_in),
    .ce_in(ce_in),
    .bus_init_in(bus_init_in),
    .wr_in(ctl_wr),
    .lanes_in(lanes),
    .wdata_in(req_wdata_in),
    .value_out(ctl_value)
  );

  // ---------------------------------------------------------------
  // Cycle sequencer
  // ---------------------------------------------------------------
  always_comb begin
    r_nxt = r;
    case (r.state)
      ST_IDLE: begin
        if (take) begin
          r_nxt.state = ST_LOOK;
          r_nxt.mem_addr = arr_addr;
          r_nxt.set = ctl_hit ? '0 : set_sel; // R16
          r_nxt.write = req_write_in;
          r_nxt.lanes = lanes;
          r_nxt.wdata = req_wdata_in;
          r_nxt.ctl_hit = ctl_hit;
        end
      end
      ST_LOOK: begin
        r_nxt.state = ST_ANSWER;
        if (!r.write) begin
          r_nxt.rdata = r.ctl_hit ? ctl_value : mem_rdata_in; // R23
        end
      end
      ST_ANSWER: begin
        r_nxt.state = ST_IDLE;
      end
      default: begin
        r_nxt.state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      r <= '0;
    end else if (ce_in) begin
      r <= r_nxt;
    end
  end

  // A refused request never leaves idle, so no reply is ever formed
  assign reply_out = (r.state == ST_ANSWER); // R13 R21
  assign rdata_out = r.rdata;
  assign mem_addr_out = r.mem_addr;
  assign mem_set_out = r.set;
  assign mem_strobe_out = (r.state == ST_LOOK) && !r.ctl_hit;
  assign mem_write_out = r.write && (r.state == ST_LOOK) && !r.ctl_hit;
  assign mem_lanes_out = r.lanes;
  assign mem_wdata_out = r.wdata;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  chk_take_reply_two: assert property ( // R2
    @(posedge ref_clk_in) disable iff (reset_in || !ce_in)
    take |=> (r.state == ST_LOOK) ##1 reply_out ##1 !reply_out)
    else $error("reply not two cycles after accepted request");

  chk_closed_no_reply: assert property ( // R13
    @(posedge ref_clk_in) disable iff (reset_in || !ce_in)
    (r.state == ST_IDLE && req_in && cfg_paged_in && !ctl_value[CTL_OPEN_BIT] && !ctl_hit)
      |=> ((r.state == ST_IDLE) && !reply_out) ##1 !reply_out)
    else $error("closed window produced a reply");

  chk_io_page_quiet: assert property ( // R5
    @(posedge ref_clk_in) disable iff (reset_in || !ce_in)
    (r.state == ST_IDLE && req_in && io_page) |=> !mem_strobe_out ##1 !mem_strobe_out)
    else $error("array accessed inside the I/O page");

  chk_write_inhibit: assert property ( // R18
    @(posedge ref_clk_in) disable iff (reset_in || !ce_in)
    (r.state == ST_IDLE && req_in && req_write_in && !cfg_write_ok_in && !ctl_hit)
      |=> (r.state == ST_IDLE))
    else $error("write accepted while writes inhibited");

  // Paged mode takes array bit 11 from the page, so only bits 10..0 pass there
  chk_low_bits_pass: assert property ( // R20 R22
    @(posedge ref_clk_in) disable iff (reset_in || !ce_in)
    take |=> (mem_addr_out[OFF_W-1:0] == $past(req_addr_in[OFF_W-1:0])) &&
      ($past(cfg_paged_in) || (mem_addr_out[WIN_BIT] == $past(req_addr_in[WIN_BIT]))))
    else $error("low address bits altered");

  chk_window_page: assert property ( // R22
    @(posedge ref_clk_in) disable iff (reset_in || !ce_in)
    (take && cfg_paged_in && !ctl_hit) |=>
      (mem_addr_out[ARR_AW-1:OFF_W] == ($past(req_addr_in[WIN_BIT])
        ? $past(ctl_value[CTL_PAGE1_LSB +: PAGE_W])
        : $past(ctl_value[CTL_PAGE0_LSB +: PAGE_W]))))
    else $error("window mapped to wrong page");

  chk_direct_range: assert property ( // R21
    @(posedge ref_clk_in) disable iff (reset_in || !ce_in)
    (take && !cfg_paged_in && cfg_addr_mode_in == AMODE_22) |->
      (req_addr_in >= {cfg_start_in, 12'h000}))
    else $error("direct access taken below start address");

  chk_ctl_readback: assert property ( // R23
    @(posedge ref_clk_in) disable iff (reset_in || !ce_in)
    (take && ctl_hit && !req_write_in) |=> ##1 (rdata_out == $past(ctl_value, 2)))
    else $error("control register read returned wrong value");

  chk_open_window_reply: assert property ( // R12
    @(posedge ref_clk_in) disable iff (reset_in || !ce_in)
    (r.state == ST_IDLE && req_in && cfg_paged_in && !req_write_in && seg_hit &&
      !io_page && ctl_value[CTL_OPEN_BIT] && in_range) |-> ##2 reply_out)
    else $error("open window read got no reply");

  chk_set_onehot: assert property ( // R16
    @(posedge ref_clk_in) disable iff (reset_in || !ce_in)
    mem_strobe_out |-> $onehot(mem_set_out))
    else $error("array strobe without exactly one chip set");

  chk_direct_offset: assert property ( // R2 R3
    @(posedge ref_clk_in) disable iff (reset_in || !ce_in)
    (take && !cfg_paged_in) |=>
      (BUS_AW'(mem_addr_out) == $past(eff - {cfg_start_in, LOW_W'(0)})))
    else $error("direct address not offset from start");

  chk_byte_keeps_other: assert property ( // R10
    @(posedge ref_clk_in) disable iff (reset_in || !ce_in)
    (ctl_wr && !bus_init_in && req_byte_in) |=> ($past(eff[0])
      ? (ctl_value[CTL_PAGE1_LSB-1:0] == $past(ctl_value[CTL_PAGE1_LSB-1:0]))
      : (ctl_value[CTL_W-1:CTL_PAGE1_LSB] == $past(ctl_value[CTL_W-1:CTL_PAGE1_LSB]))))
    else $error("byte write disturbed the other window byte");

  chk_ctl_no_strobe: assert property ( // R23
    @(posedge ref_clk_in) disable iff (reset_in || !ce_in)
    (take && ctl_hit) |=> (!mem_strobe_out && !mem_write_out))
    else $error("control register access reached the array");

  // Stalled enable must hold every bit, the register included
  chk_ce_freeze: assert property (
    @(posedge ref_clk_in) disable iff (reset_in)
    !ce_in |=> (r == $past(r)) && (ctl_value == $past(ctl_value)))
    else $error("state moved while clock enable low");

endmodule : prw_window_decoder

/* prw_mem_model.sv */
// Byte-pair memory array model facing the decoder's array port.
// Assumes address and lanes hold steady through the strobe cycle.
`timescale 1ns/1ps
module prw_mem_model (
  input wire logic ref_clk_in,
  input wire logic [17:0] addr_in,
  input wire logic strobe_in,
  input wire logic write_in,
  input wire logic [1:0] lanes_in,
  input wire logic [15:0] wdata_in,
  output logic [15:0] rdata_out
);
  logic [15:0] mem [0:131071];
  logic [15:0] junk;

  initial begin
    junk = 16'h0f0f;
    for (int i = 0; i < 131072; i++) begin
      mem[i] = i[15:0] ^ 16'h5a3c;
    end
  end

  // Off-strobe data flips each cycle so a late sample shows up
  assign rdata_out = strobe_in ? mem[addr_in[17:1]] : junk;

  always @(posedge ref_clk_in) begin
    junk <= ~junk;
    if (strobe_in && write_in) begin
      if (lanes_in[0]) mem[addr_in[17:1]][7:0] <= wdata_in[7:0];
      if (lanes_in[1]) mem[addr_in[17:1]][15:8] <= wdata_in[15:8];
    end
  end
endmodule : prw_mem_model

/* tb.sv */
// Self-checking bench for the paged ROM window decoder, acting as bus master.
// Assumes the array model answers within the strobe cycle.
`timescale 1ns/1ps
module tb;
  import prw_pkg::*;
  logic clk, rst, binit, ce, paged, wok, req, wr, bt, rep, mstb, mwr, w;
  logic [9:0] start, s;
  logic [1:0] pat, amode, mlanes;
  logic [3:0] sel;
  logic [21:0] addr;
  logic [15:0] wd, rd, mrd, mwd, got;
  logic [17:0] maddr, c, a18;
  logic [7:0] mset;
  logic [31:0] seed, r;
  logic [10:0] o;
  logic [6:0] p0, p1, pg;
  int miscompares, n_checks, cyc;

  prw_window_decoder u_prw_window_decoder (.ref_clk_in(clk), .reset_in(rst), .ce_in(ce),
    .bus_init_in(binit), .cfg_paged_in(paged), .cfg_start_in(start), .cfg_pattern_in(pat),
    .cfg_ctl_sel_in(sel), .cfg_write_ok_in(wok), .cfg_addr_mode_in(amode), .req_in(req),
    .req_addr_in(addr), .req_write_in(wr), .req_byte_in(bt), .req_wdata_in(wd),
    .reply_out(rep), .rdata_out(rd), .mem_addr_out(maddr), .mem_set_out(mset),
    .mem_strobe_out(mstb), .mem_write_out(mwr), .mem_lanes_out(mlanes),
    .mem_wdata_out(mwd), .mem_rdata_in(mrd));
  prw_mem_model u_prw_mem_model (.ref_clk_in(clk), .addr_in(maddr), .strobe_in(mstb),
    .write_in(mwr), .lanes_in(mlanes), .wdata_in(mwd), .rdata_out(mrd));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  function automatic logic [15:0] fw(input logic [17:0] a);
    return a[16:1] ^ 16'h5a3c;
  endfunction : fw
  function automatic logic [17:0] cap(input logic [1:0] t);
    return t == PAT_2K_HALF ? CAP_2K_HALF : t == PAT_2K_FULL ? CAP_2K_FULL :
      t == PAT_4K_FULL ? CAP_4K_FULL : CAP_8K_FULL;
  endfunction : cap
  function automatic int sh(input logic [1:0] t);
    return t == PAT_4K_FULL ? SET_SH_4K : t == PAT_8K_FULL ? SET_SH_8K : SET_SH_2K;
  endfunction : sh
  function automatic logic [21:0] ca(input logic [3:0] n);
    return 22'h3ffe00 + {17'h0, n, 1'b0};
  endfunction : ca

  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    n_checks++;
    if (g !== x) begin
      miscompares++;
      $display("[ERR] %0t got %h exp %h", $time, g, x);
    end
  endtask : chk

  task automatic end_sim();
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : end_sim

  task automatic rs(input logic p, input logic [9:0] st, input logic [1:0] t,
      input logic [1:0] m);
    @(posedge clk);
    rst <= 1'b1;
    paged <= p;
    start <= st;
    pat <= t;
    amode <= m;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
  endtask : rs

  // Holds the request until the reply edge, then drops it for a cycle
  task automatic acc(input logic [21:0] a, input logic wi, input logic b,
      input logic [15:0] d, input logic e);
    int k;
    k = 0;
    @(posedge clk);
    req <= 1'b1;
    addr <= a;
    wr <= wi;
    bt <= b;
    wd <= d;
    while (k < 8 && rep !== 1'b1) begin
      @(negedge clk);
      k++;
    end
    chk(32'(rep === 1'b1), 32'(e));
    if (e) chk(k, 3);
    got = rd;
    @(posedge clk);
    req <= 1'b0;
  endtask : acc

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      miscompares++;
      end_sim();
    end
  end

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  initial begin
    {rst, binit, ce, paged, wok, req, wr, bt} = 8'ha0;
    {start, pat, amode, sel, addr, wd} = '0;
    {miscompares, n_checks, cyc} = '0;
    seed = 32'h1972;
    rs(1'b1, 10'h155, PAT_8K_FULL, AMODE_22);
    acc(ca(sel), 1'b0, 1'b0, 16'h0, 1'b1);
    chk(got, CTL_RESET);
    acc(22'h155000, 1'b0, 1'b0, 16'h0, 1'b0);
    for (int n = 0; n < 16; n++) begin
      sel <= n[3:0];
      r = rnd();
      acc(ca(n[3:0]), 1'b1, 1'b0, r[15:0], 1'b1);
      acc(ca(n[3:0]), 1'b0, 1'b0, 16'h0, 1'b1);
      chk(got, r[15:0]);
      acc(ca(n[3:0] ^ 4'h1), 1'b0, 1'b0, 16'h0, 1'b0);
    end
    // Master loads pages and enable before any window use
    for (int i = 0; i < 24; i++) begin
      r = rnd();
      p0 = {1'b0, r[5:0]};
      p1 = {1'b0, r[13:8]};
      acc(ca(sel), 1'b1, 1'b0, {9'h100, p0}, 1'b1);
      acc(ca(sel) | 22'h1, 1'b1, 1'b1, {1'b1, p1, 8'h00}, 1'b1);
      acc(ca(sel), 1'b0, 1'b0, 16'h0, 1'b1);
      chk(got, {1'b1, p1, 1'b0, p0});
      o = r[26:16];
      w = r[27];
      pg = w ? p1 : p0;
      acc({10'h155, w, o}, 1'b0, 1'b0, 16'h0, 1'b1);
      chk(got, fw({pg, o}));
      chk(maddr, {pg, o});
    end
    acc(ca(sel), 1'b1, 1'b1, 16'h0003, 1'b1);
    acc(ca(sel), 1'b0, 1'b0, 16'h0, 1'b1);
    chk(got, {1'b1, p1, 8'h03});
    acc({10'h155, 1'b0, o}, 1'b0, 1'b0, 16'h0, 1'b1);
    chk(got, fw({7'h03, o}));
    acc(ca(sel), 1'b1, 1'b0, 16'h8040, 1'b1);
    acc(22'h155000, 1'b0, 1'b0, 16'h0, 1'b0);
    acc(22'h1557fe, 1'b0, 1'b0, 16'h0, 1'b0);
    acc(22'h155800, 1'b0, 1'b0, 16'h0, 1'b1);
    chk(got, fw(18'h0));
    @(posedge clk);
    binit <= 1'b1;
    @(posedge clk);
    binit <= 1'b0;
    acc(ca(sel), 1'b0, 1'b0, 16'h0, 1'b1);
    chk(got, CTL_RESET);
    acc(22'h155800, 1'b0, 1'b0, 16'h0, 1'b0);
    $display("test paged done");
    for (int t = 0; t < 4; t++) begin
      r = rnd();
      s = {1'b0, r[8:0]};
      rs(1'b0, s, t[1:0], AMODE_22);
      c = cap(t[1:0]);
      for (int i = 0; i < 6; i++) begin
        r = rnd();
        a18 = i == 0 ? c - 18'h1 : r[17:0] & (c - 18'h1);
        acc({s, 12'h0} + {4'h0, a18}, 1'b0, 1'b0, 16'h0, 1'b1);
        chk(got, fw(a18));
        chk(mset, 32'h1 << (a18 >> sh(t[1:0])));
      end
      acc({s, 12'h0} + {4'h0, c}, 1'b0, 1'b0, 16'h0, 1'b0);
      acc({s, 12'h0} - 22'h1, 1'b0, 1'b0, 16'h0, 1'b0);
    end
    rs(1'b0, 10'h3fd, PAT_8K_FULL, AMODE_22);
    acc(22'h3fd000, 1'b0, 1'b0, 16'h0, 1'b1);
    acc(22'h3fe000, 1'b0, 1'b0, 16'h0, 1'b0);
    acc(ca(4'h0), 1'b0, 1'b0, 16'h0, 1'b0);
    rs(1'b0, 10'h000, PAT_8K_FULL, AMODE_16);
    acc(22'h00e000, 1'b0, 1'b0, 16'h0, 1'b0);
    acc(22'h00d000, 1'b0, 1'b0, 16'h0, 1'b1);
    rs(1'b0, 10'h000, PAT_8K_FULL, AMODE_18);
    acc(22'h03e000, 1'b0, 1'b0, 16'h0, 1'b0);
    acc(22'h3c1000, 1'b0, 1'b0, 16'h0, 1'b1);
    chk(got, fw(18'h01000));
    rs(1'b0, 10'h000, PAT_8K_FULL, AMODE_22);
    acc(22'h00e000, 1'b0, 1'b0, 16'h0, 1'b1);
    acc(22'h080000, 1'b0, 1'b0, 16'h0, 1'b0);
    // Enable low stalls the decoder, so a valid read goes unanswered
    ce <= 1'b0;
    acc(22'h00e000, 1'b0, 1'b0, 16'h0, 1'b0);
    ce <= 1'b1;
    acc(22'h000100, 1'b1, 1'b0, 16'hbeef, 1'b0);
    wok <= 1'b1;
    acc(22'h000100, 1'b1, 1'b0, 16'hbeef, 1'b1);
    acc(22'h000101, 1'b1, 1'b1, 16'h1200, 1'b1);
    acc(22'h000100, 1'b0, 1'b0, 16'h0, 1'b1);
    chk(got, 16'h12ef);
    $display("test direct done");
    end_sim();
  end
endmodule : tb
